// file: test/tb_top.sv
// Self-checking bench for the clock and flash pulse control block
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import mcfp_pkg::*;
;
   typedef struct {
      logic [7:0] wdat;
      logic [7:0] rd;
      logic osc;
      logic key;
      logic card;
      logic [4:0] ratio;
   } mcfp_row_t;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic [ADR_W-1:0] i_wb_adr = '0;
   logic [3:0] i_wb_sel = 4'h0;
   logic [31:0] i_wb_dat = '0;
   logic i_flash_rd = 1'b0;
   logic [31:0] o_wb_dat;
   logic o_wb_ack;
   logic o_flash_rd;
   logic o_osc_off;
   logic o_keypad_clk_en;
   logic o_card_clk_en;
   logic o_card_detect_en;
   logic [MULT_W-1:0] o_vco_mult;
   logic [RATIO_W-1:0] o_vco_ratio;
   int fails = 0;
   int num_checks = 0;
   logic [31:0] rdat;
   int cnt;
   localparam logic [ADR_W-1:0] A_MCLK = 18'h0_023C;
   localparam logic [ADR_W-1:0] A_FPC = 18'h3_FFC8;
   localparam logic [ADR_W-1:0] A_PDC = 18'h3_FFC4;
   localparam logic [ADR_W-1:0] A_STAT = 18'h3_FFCC;
   localparam logic [ADR_W-1:0] A_NONE = 18'h0_0100;
   mcfp_row_t rows [8] = '{
      '{8'h00, 8'h00, 1'b0, 1'b1, 1'b1, 5'h04},
      '{8'h81, 8'h81, 1'b1, 1'b1, 1'b1, 5'h06},
      '{8'h42, 8'h42, 1'b0, 1'b0, 1'b1, 5'h08},
      '{8'h23, 8'h23, 1'b0, 1'b1, 1'b0, 5'h0A},
      '{8'hE4, 8'hE4, 1'b1, 1'b0, 1'b0, 5'h0C},
      '{8'h1D, 8'h05, 1'b0, 1'b1, 1'b1, 5'h0E},
      '{8'h06, 8'h06, 1'b0, 1'b1, 1'b1, 5'h10},
      '{8'hFF, 8'hE7, 1'b1, 1'b0, 1'b0, 5'h12}
   };

   mcfp_clk_ctl dut (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we),
      .i_wb_adr(i_wb_adr),
      .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack),
      .i_flash_rd(i_flash_rd),
      .o_flash_rd(o_flash_rd),
      .o_osc_off(o_osc_off),
      .o_keypad_clk_en(o_keypad_clk_en),
      .o_card_clk_en(o_card_clk_en),
      .o_card_detect_en(o_card_detect_en),
      .o_vco_mult(o_vco_mult),
      .o_vco_ratio(o_vco_ratio)
   );

   always #2 i_sys_clk = ~i_sys_clk;

   task automatic chk_dat(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_dat

   task automatic chk_bit(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_cnt(input string nm, input int e, input int g);
      num_checks++;
      if (g != e) begin
         fails++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt

   // Classic cycle; outputs are registered, so the value read right
   // after the edge is the one the edge sampled
   task automatic bus(input logic we, input logic [ADR_W-1:0] a,
                      input logic [7:0] d, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_sel <= sel;
      i_wb_dat <= {24'h00_0000, d};
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 100);
      rdat = o_wb_dat;
      if (n >= 100) fails++;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
      @(posedge i_sys_clk);
   endtask : bus

   // Holds the strobe for n cycles and counts cycles the output is high
   task automatic pulse(input int n, output int w);
      w = 0;
      @(posedge i_sys_clk);
      i_flash_rd <= 1'b1;
      repeat (n) begin
         @(posedge i_sys_clk);
         w += (o_flash_rd === 1'b1);
      end
      i_flash_rd <= 1'b0;
      repeat (30) begin
         @(posedge i_sys_clk);
         w += (o_flash_rd === 1'b1);
      end
   endtask : pulse

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   initial begin
      #40000;
      fails++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk);
      #1;
      chk_dat("ratio", 32'(5'h08), 32'(o_vco_ratio));
      chk_dat("mult", 32'(3'h2), 32'(o_vco_mult));
      chk_bit("osc_off", 1'b0, o_osc_off);
      bus(1'b0, A_MCLK, 8'h00, 4'hF);
      chk_dat("mclk reset", 32'h0000_000A, rdat);
      bus(1'b0, A_FPC, 8'h00, 4'hF);
      chk_dat("fpc reset", 32'h0000_0010, rdat);
      $display("test reset done");
      foreach (rows[i]) begin
         bus(1'b1, A_MCLK, rows[i].wdat, 4'hF);
         chk_bit("osc_off", rows[i].osc, o_osc_off);
         chk_bit("key_en", rows[i].key, o_keypad_clk_en);
         chk_bit("card_en", rows[i].card, o_card_clk_en);
         chk_bit("detect", 1'b1, o_card_detect_en);
         chk_dat("ratio", 32'(rows[i].ratio), 32'(o_vco_ratio));
         chk_dat("mult", 32'(rows[i].wdat[2:0]), 32'(o_vco_mult));
         bus(1'b0, A_MCLK, 8'h00, 4'hF);
         chk_dat("mclk rd", 32'(rows[i].rd), rdat);
      end
      $display("test table done");
      bus(1'b1, A_FPC, 8'hFF, 4'hF);
      bus(1'b0, A_FPC, 8'h00, 4'hF);
      chk_dat("fpc rd", 32'h0000_0030, rdat);
      bus(1'b1, A_FPC, 8'h00, 4'hE);
      bus(1'b0, A_FPC, 8'h00, 4'hF);
      chk_dat("fpc sel", 32'h0000_0030, rdat);
      bus(1'b0, A_NONE, 8'h00, 4'hF);
      chk_dat("unmapped", 32'h0000_0000, rdat);
      $display("test reserved done");
      pulse(20, cnt);
      chk_cnt("pass width", 20, cnt);
      bus(1'b1, A_FPC, 8'h10, 4'hF);
      pulse(20, cnt);
      chk_cnt("long width", 16, cnt);
      pulse(5, cnt);
      chk_cnt("early end", 5, cnt);
      bus(1'b1, A_FPC, 8'h00, 4'hF);
      pulse(20, cnt);
      chk_cnt("short width", 10, cnt);
      $display("test flash done");
      bus(1'b1, A_MCLK, 8'h03, 4'hF);
      bus(1'b1, A_PDC, 8'h80, 4'hF);
      cnt = 0;
      do begin
         @(posedge i_sys_clk);
         cnt++;
         if (cnt == 1) begin
            chk_bit("pd key", 1'b0, o_keypad_clk_en);
            chk_bit("pd card", 1'b0, o_card_clk_en);
         end
      end while (o_osc_off !== 1'b1 && cnt < 60);
      // Count starts two edges after the write edge, and the output
      // flop is seen one edge after it switches
      chk_cnt("pd delay", PD_DELAY_CYC + 1, cnt);
      bus(1'b0, A_MCLK, 8'h00, 4'hF);
      chk_dat("pd keeps", 32'h0000_0003, rdat);
      bus(1'b0, A_STAT, 8'h00, 4'hF);
      chk_dat("pd status", 32'h0000_000F, rdat);
      bus(1'b1, A_PDC, 8'h00, 4'hF);
      // The oscillator output trails the state machine by one edge
      @(posedge i_sys_clk);
      chk_bit("pd clear", 1'b0, o_osc_off);
      chk_bit("key back", 1'b1, o_keypad_clk_en);
      $display("test power down done");
      // Reset in mid power-down must abort it and restore the defaults
      bus(1'b1, A_MCLK, 8'hFF, 4'hF);
      bus(1'b1, A_PDC, 8'h80, 4'hF);
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk);
      #1;
      chk_bit("rst osc_off", 1'b0, o_osc_off);
      chk_bit("rst key_en", 1'b1, o_keypad_clk_en);
      chk_bit("rst card_en", 1'b1, o_card_clk_en);
      chk_bit("rst detect", 1'b1, o_card_detect_en);
      chk_dat("rst ratio", 32'(5'h08), 32'(o_vco_ratio));
      chk_dat("rst mult", 32'(3'h2), 32'(o_vco_mult));
      bus(1'b0, A_MCLK, 8'h00, 4'hF);
      chk_dat("rst mclk", 32'h0000_000A, rdat);
      bus(1'b0, A_FPC, 8'h00, 4'hF);
      chk_dat("rst fpc", 32'h0000_0010, rdat);
      bus(1'b0, A_PDC, 8'h00, 4'hF);
      chk_dat("rst pdc", 32'h0000_0000, rdat);
      $display("test mid reset done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire

// file: verilog/mcfp_clk_ctl.sv
// Master clock control, power-down sequencing and flash pulse control
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Passthrough bit set forwards the flash read strobe unchanged.
// - Passthrough clear limits each strobe to a one-shot counted in system clock cycles.
// - Shortened pulse is about 66ns with long select, else about 40ns.
// - Oscillator disable bit at 1 stops crystal oscillator and VCO/PLL.
// - Power-down stops oscillator and VCO/PLL but keeps the stored bit.
// - Keypad clock disable gates keypad clock; power-down gates it too.
// - Card clock disable gates card clock; power-down gates it too.
// - Card insertion and removal detection stays alive with card clock off.
// - VCO ratio to crystal equals multiplier value times two plus four.
// - Master clock register resets to 0x0A, multiplier two, ratio eight.
// - Flash pulse register resets to 0x10: long select on, passthrough off.
// - Oscillator and VCO/PLL stop 34 cycles after the power-down request bit is set (32-cycle wait).
module mcfp_clk_ctl
   import mcfp_pkg::*;
(
   input wire logic i_sys_clk,           // System clock, 250 MHz
   input wire logic i_rst,               // Synchronous reset, active high
   input wire logic i_wb_cyc,            // Wishbone cycle
   input wire logic i_wb_stb,            // Wishbone strobe
   input wire logic i_wb_we,             // Wishbone write enable
   input wire logic [ADR_W-1:0] i_wb_adr, // Wishbone byte address
   input wire logic [3:0] i_wb_sel,      // Wishbone byte selects
   input wire logic [31:0] i_wb_dat,     // Wishbone write data
   output logic [31:0] o_wb_dat,         // Wishbone read data
   output logic o_wb_ack,                // Wishbone acknowledge
   input wire logic i_flash_rd,          // Flash read strobe from the CPU
   output logic o_flash_rd,              // Flash read strobe to the flash
   output logic o_osc_off,               // Oscillator and VCO/PLL off
   output logic o_keypad_clk_en,         // Keypad logic clock enable
   output logic o_card_clk_en,           // Smart card logic clock enable
   output logic o_card_detect_en,        // Card insert/remove detect enable
   output logic [MULT_W-1:0] o_vco_mult, // Multiplier value
   output logic [RATIO_W-1:0] o_vco_ratio // VCO to crystal ratio
);
   logic [7:0] mclk_q;
   logic [7:0] fpc_q;
   logic [7:0] pdc_q;
   logic [7:0] stat_w;
   logic ack_q;
   logic [31:0] rdat_q;
   logic req_w;
   logic wr_w;
   mcfp_pd_state_t pd_state_q;
   logic [PD_CNT_W-1:0] pd_cnt_q;
   logic osc_off_q;
   logic key_en_q;
   logic card_en_q;
   logic detect_q;
   logic [MULT_W-1:0] mult_q;
   logic [RATIO_W-1:0] ratio_q;
   logic pd_down_w;

   mcfp_shot_if shot_bus ();

   // Bus request: a new access is taken only while no ack is pending,
   // which gives exactly one ack per classic cycle
   assign req_w = i_wb_cyc && i_wb_stb && !ack_q;
   assign wr_w = req_w && i_wb_we && i_wb_sel[0];

   // Merges a write byte into a register, keeping reserved bits zero
   function automatic logic [7:0] merge_wr(input logic [7:0] data,
                                           input logic [7:0] mask);
      merge_wr = data & mask;
   endfunction : merge_wr

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_w;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         mclk_q <= MCLK_RST;
      end else if (wr_w && i_wb_adr == mcfp_byte_addr(MCLK_IDX)) begin
         mclk_q <= merge_wr(i_wb_dat[7:0], MCLK_MASK);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         fpc_q <= FPC_RST;
      end else if (wr_w && i_wb_adr == mcfp_byte_addr(FPC_IDX)) begin
         fpc_q <= merge_wr(i_wb_dat[7:0], FPC_MASK);
      end
   end

   // Power-down request; cleared only by software or reset
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pdc_q <= PDC_RST;
      end else if (wr_w && i_wb_adr == mcfp_byte_addr(PDC_IDX)) begin
         pdc_q <= merge_wr(i_wb_dat[7:0], PDC_MASK);
      end
   end

   always_comb begin
      stat_w = 8'h00;
      stat_w[STAT_OSC_OFF_BIT] = osc_off_q;
      stat_w[STAT_KEY_OFF_BIT] = !key_en_q;
      stat_w[STAT_CARD_OFF_BIT] = !card_en_q;
      stat_w[STAT_PD_DONE_BIT] = pd_down_w;
   end

   // Read data; unmapped addresses answer with zero and ignore writes
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rdat_q <= 32'h0000_0000;
      end else if (req_w && !i_wb_we) begin
         case (i_wb_adr)
            mcfp_byte_addr(MCLK_IDX): rdat_q <= {24'h00_0000, mclk_q};
            mcfp_byte_addr(FPC_IDX): rdat_q <= {24'h00_0000, fpc_q};
            mcfp_byte_addr(PDC_IDX): rdat_q <= {24'h00_0000, pdc_q};
            mcfp_byte_addr(STAT_IDX): rdat_q <= {24'h00_0000, stat_w};
            default: rdat_q <= 32'h0000_0000;
         endcase
      end else begin
         rdat_q <= 32'h0000_0000;
      end
   end

   // Power-down sequence: the delay leaves the CPU time to stop itself
   // before its clock source goes away
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pd_state_q <= PD_RUN;
         pd_cnt_q <= '0;
      end else begin
         case (pd_state_q)
            PD_RUN: begin
               pd_cnt_q <= '0;
               if (pdc_q[PDC_REQ_BIT]) begin
                  pd_state_q <= PD_WAIT;
               end
            end
            PD_WAIT: begin
               if (!pdc_q[PDC_REQ_BIT]) begin
                  pd_state_q <= PD_RUN;
               end else if (pd_cnt_q == PD_DELAY_LAST) begin
                  pd_state_q <= PD_DOWN;
               end else begin
                  pd_cnt_q <= pd_cnt_q + 1'b1;
               end
            end
            PD_DOWN: begin
               if (!pdc_q[PDC_REQ_BIT]) begin
                  pd_state_q <= PD_RUN;
               end
            end
            default: pd_state_q <= PD_RUN;
         endcase
      end
   end

   assign pd_down_w = (pd_state_q == PD_DOWN);

   // Power-down overrides the stored disables without touching them
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         osc_off_q <= 1'b0;
      end else begin
         osc_off_q <= mclk_q[MCLK_OSC_DIS_BIT] || pd_down_w;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         key_en_q <= 1'b1;
         card_en_q <= 1'b1;
      end else begin
         key_en_q <= !mclk_q[MCLK_KEY_DIS_BIT]
                     && !pdc_q[PDC_REQ_BIT];
         card_en_q <= !mclk_q[MCLK_CARD_DIS_BIT]
                      && !pdc_q[PDC_REQ_BIT];
      end
   end

   // Detection must survive both card clock gating and power-down
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         detect_q <= 1'b0;
      end else begin
         detect_q <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         mult_q <= MCLK_RST[MCLK_MULT_LSB +: MULT_W];
         ratio_q <= {1'b0, MCLK_RST[MCLK_MULT_LSB +: MULT_W], 1'b0}
                    + RATIO_OFFSET;
      end else begin
         mult_q <= mclk_q[MCLK_MULT_LSB +: MULT_W];
         ratio_q <= {1'b0, mclk_q[MCLK_MULT_LSB +: MULT_W], 1'b0}
                    + RATIO_OFFSET;
      end
   end

   assign shot_bus.rd_req = i_flash_rd;
   assign shot_bus.pass = fpc_q[FPC_PASS_BIT];
   assign shot_bus.long_sel = fpc_q[FPC_LONG_BIT];

   mcfp_read_shot u_shot (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .shot      (shot_bus.shot)
   );

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;
   assign o_flash_rd = shot_bus.rd_out;
   assign o_osc_off = osc_off_q;
   assign o_keypad_clk_en = key_en_q;
   assign o_card_clk_en = card_en_q;
   assign o_card_detect_en = detect_q;
   assign o_vco_mult = mult_q;
   assign o_vco_ratio = ratio_q;

   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   logic [5:0] hi_run_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !o_flash_rd) begin
         hi_run_q <= '0;
      end else if (hi_run_q != 6'h3F) begin
         hi_run_q <= hi_run_q + 1'b1;
      end
   end

   pass_follow_a: assert property (
      fpc_q[FPC_PASS_BIT] && $past(fpc_q[FPC_PASS_BIT])
      |-> o_flash_rd == $past(i_flash_rd))
      else $error("passthrough strobe differs from input");

   short_len_a: assert property (
      !fpc_q[FPC_PASS_BIT] && !fpc_q[FPC_LONG_BIT]
      && $stable(fpc_q) |-> hi_run_q <= 6'(PULSE_SHORT_CYC))
      else $error("short pulse too long");

   long_len_a: assert property (
      !fpc_q[FPC_PASS_BIT] && fpc_q[FPC_LONG_BIT] && i_flash_rd
      && !$past(i_flash_rd) ##1 (i_flash_rd && $stable(fpc_q))[*8]
      ##1 (i_flash_rd && $stable(fpc_q))[*8]
      |-> ##1 !o_flash_rd)
      else $error("long pulse not ended on time");

   osc_dis_a: assert property (
      mclk_q[MCLK_OSC_DIS_BIT] |=> o_osc_off)
      else $error("oscillator not off when disabled");

   pd_keep_a: assert property (
      pdc_q[PDC_REQ_BIT] && !wr_w |=> $stable(mclk_q))
      else $error("power-down altered stored bits");

   // Request held for the whole wait; the output flop adds one edge
   pd_delay_a: assert property (
      $rose(pdc_q[PDC_REQ_BIT]) && !mclk_q[MCLK_OSC_DIS_BIT]
      ##1 (pdc_q[PDC_REQ_BIT] && !mclk_q[MCLK_OSC_DIS_BIT])[*8]
      ##1 (pdc_q[PDC_REQ_BIT] && !mclk_q[MCLK_OSC_DIS_BIT])[*8]
      ##1 (pdc_q[PDC_REQ_BIT] && !mclk_q[MCLK_OSC_DIS_BIT])[*8]
      ##1 (pdc_q[PDC_REQ_BIT] && !mclk_q[MCLK_OSC_DIS_BIT])[*8]
      |-> !o_osc_off ##1 !o_osc_off ##1 o_osc_off)
      else $error("oscillator off at wrong time after power-down");

   gate_key_a: assert property (
      pdc_q[PDC_REQ_BIT] || mclk_q[MCLK_KEY_DIS_BIT] |=> !o_keypad_clk_en)
      else $error("keypad clock not gated");

   gate_card_a: assert property (
      pdc_q[PDC_REQ_BIT] || mclk_q[MCLK_CARD_DIS_BIT] |=> !o_card_clk_en)
      else $error("card clock not gated");

   detect_on_a: assert property (
      !o_card_clk_en |-> o_card_detect_en)
      else $error("card detect lost with card clock off");

   ratio_a: assert property (
      ##1 o_vco_ratio == RATIO_W'({$past(mclk_q[2:0]), 1'b0}) + RATIO_OFFSET)
      else $error("VCO ratio wrong");

   // Bit 3 of the master register leaves reset set, as its reset value
   // asks; only a write clears it
   resvd_a: assert property (
      (mclk_q & ~(MCLK_MASK | MCLK_RST)) == 8'h00
      && (fpc_q & ~FPC_MASK) == 8'h00)
      else $error("reserved bit set");

   resvd_wr_a: assert property (
      wr_w && i_wb_adr == mcfp_byte_addr(MCLK_IDX)
      |=> (mclk_q & ~MCLK_MASK) == 8'h00)
      else $error("reserved bit kept after write");

   ack_one_a: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");

   ack_next_a: assert property (
      req_w |=> o_wb_ack)
      else $error("ack not given one cycle after request");

   rdat_idle_a: assert property (
      !o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("read data not zero outside ack");

   shot_start_a: assert property (
      !fpc_q[FPC_PASS_BIT] && $rose(i_flash_rd) |=> o_flash_rd)
      else $error("shortened pulse did not start");

   osc_on_a: assert property (
      !mclk_q[MCLK_OSC_DIS_BIT] && !pd_down_w |=> !o_osc_off)
      else $error("oscillator off without cause");

   key_on_a: assert property (
      !pdc_q[PDC_REQ_BIT] && !mclk_q[MCLK_KEY_DIS_BIT] |=> o_keypad_clk_en)
      else $error("keypad clock gated without cause");

   card_on_a: assert property (
      !pdc_q[PDC_REQ_BIT] && !mclk_q[MCLK_CARD_DIS_BIT] |=> o_card_clk_en)
      else $error("card clock gated without cause");

   pd_clear_a: assert property (
      !pdc_q[PDC_REQ_BIT] |=> !pd_down_w)
      else $error("power-down held after request cleared");

   mult_out_a: assert property (
      ##1 o_vco_mult == $past(mclk_q[MCLK_MULT_LSB +: MULT_W]))
      else $error("VCO multiplier output wrong");

   shot_short_c: cover property (
      !fpc_q[FPC_PASS_BIT] && $fell(o_flash_rd) && i_flash_rd);
   shot_long_c: cover property (
      !fpc_q[FPC_PASS_BIT] && fpc_q[FPC_LONG_BIT] && $fell(o_flash_rd));
   pd_done_c: cover property ($rose(pd_down_w));
   mclk_wr_c: cover property (
      wr_w && i_wb_adr == mcfp_byte_addr(MCLK_IDX));
endmodule : mcfp_clk_ctl
`default_nettype wire

// file: verilog/mcfp_pkg.sv
// Constants and types shared by the clock and flash pulse control block
`default_nettype none
package mcfp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] MCLK_IDX = 16'h008F;
   localparam logic [15:0] FPC_IDX = 16'hFFF2;
   localparam logic [15:0] PDC_IDX = 16'hFFF1;
   localparam logic [15:0] STAT_IDX = 16'hFFF3;
   localparam int ADR_W = 18;

   // Reset values and writable-bit masks
   localparam logic [7:0] MCLK_RST = 8'h0A;
   localparam logic [7:0] FPC_RST = 8'h10;
   localparam logic [7:0] PDC_RST = 8'h00;
   localparam logic [7:0] MCLK_MASK = 8'hE7;
   localparam logic [7:0] FPC_MASK = 8'h30;
   localparam logic [7:0] PDC_MASK = 8'h80;

   // Field positions
   localparam int MCLK_OSC_DIS_BIT = 7;
   localparam int MCLK_KEY_DIS_BIT = 6;
   localparam int MCLK_CARD_DIS_BIT = 5;
   localparam int MCLK_MULT_LSB = 0;
   localparam int MULT_W = 3;
   localparam int FPC_PASS_BIT = 5;
   localparam int FPC_LONG_BIT = 4;
   localparam int PDC_REQ_BIT = 7;
   localparam int STAT_OSC_OFF_BIT = 0;
   localparam int STAT_KEY_OFF_BIT = 1;
   localparam int STAT_CARD_OFF_BIT = 2;
   localparam int STAT_PD_DONE_BIT = 3;

   // VCO ratio = multiplier_value * 2 + 4
   localparam int RATIO_W = 5;
   localparam logic [RATIO_W-1:0] RATIO_OFFSET = 5'h04;

   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PULSE_LONG_PS = 66000;
   localparam int PULSE_SHORT_PS = 40000;
   // Longest times: round down, never below one cycle
   localparam int PULSE_LONG_CYC = (PULSE_LONG_PS / CLK_PERIOD_PS) < 1 ? 1
                                   : (PULSE_LONG_PS / CLK_PERIOD_PS);
   localparam int PULSE_SHORT_CYC = (PULSE_SHORT_PS / CLK_PERIOD_PS) < 1 ? 1
                                    : (PULSE_SHORT_PS / CLK_PERIOD_PS);
   localparam int PULSE_CNT_W = 5;
   localparam logic [PULSE_CNT_W-1:0] PULSE_LONG_LOAD =
      PULSE_CNT_W'(PULSE_LONG_CYC - 1);
   localparam logic [PULSE_CNT_W-1:0] PULSE_SHORT_LOAD =
      PULSE_CNT_W'(PULSE_SHORT_CYC - 1);
   localparam int PD_DELAY_CYC = 32;
   localparam int PD_CNT_W = 6;
   localparam logic [PD_CNT_W-1:0] PD_DELAY_LAST =
      PD_CNT_W'(PD_DELAY_CYC - 1);

   typedef enum logic [1:0] {PD_RUN, PD_WAIT, PD_DOWN} mcfp_pd_state_t;

   // Byte address of a register index
   function automatic logic [ADR_W-1:0] mcfp_byte_addr(
      input logic [15:0] idx);
      mcfp_byte_addr = {idx, 2'b00};
   endfunction : mcfp_byte_addr
endpackage : mcfp_pkg
`default_nettype wire

// file: verilog/mcfp_read_shot.sv
// One-shot that shortens the flash read strobe
`timescale 1ns/100ps
`default_nettype none
module mcfp_read_shot
   import mcfp_pkg::*;
(
   input wire logic i_sys_clk, // System clock
   input wire logic i_rst,     // Synchronous reset, active high
   mcfp_shot_if.shot shot      // Strobe in, shaped strobe out
);
   logic req_q;
   logic pulse_q;
   logic [PULSE_CNT_W-1:0] cnt_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         req_q <= 1'b0;
      end else begin
         req_q <= shot.rd_req;
      end
   end

   // Length counted in system cycles, so it is fixed in time whatever
   // rate the processor strobes at
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pulse_q <= 1'b0;
         cnt_q <= '0;
      end else if (shot.pass) begin
         pulse_q <= shot.rd_req;
         cnt_q <= '0;
      end else if (shot.rd_req && !req_q) begin
         pulse_q <= 1'b1;
         cnt_q <= shot.long_sel ? PULSE_LONG_LOAD
                                : PULSE_SHORT_LOAD;
      end else if (pulse_q) begin
         if (!shot.rd_req || cnt_q == '0) begin
            pulse_q <= 1'b0;
         end
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   assign shot.rd_out = pulse_q;
endmodule : mcfp_read_shot
`default_nettype wire

// file: verilog/mcfp_shot_if.sv
// Carrier between the control registers and the flash read one-shot
`timescale 1ns/100ps
`default_nettype none
interface mcfp_shot_if;
   logic rd_req;
   logic pass;
   logic long_sel;
   logic rd_out;
   modport ctl (output rd_req, output pass, output long_sel,
                input rd_out);
   modport shot (input rd_req, input pass, input long_sel,
                 output rd_out);
endinterface : mcfp_shot_if
`default_nettype wire
